// [core/acmvr_core.sv]
// Instruction sequencer for OR, increment, move and return instructions
`timescale 1ns/1ps
module acmvr_core (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [acmvr_pkg::OP_W-1:0] instr,
  input wire logic [acmvr_pkg::DATA_W-1:0] file_rdata,
  input wire logic [acmvr_pkg::DATA_W-1:0] page_latch,
  input wire logic push_en,
  input wire logic [acmvr_pkg::PC_W-1:0] push_addr,
  output logic [acmvr_pkg::PC_W-1:0] prog_addr,
  output logic [acmvr_pkg::ADDR_W-1:0] file_addr,
  output logic file_we,
  output logic [acmvr_pkg::DATA_W-1:0] file_wdata,
  output logic [acmvr_pkg::DATA_W-1:0] accum,
  output logic zero_flag,
  output logic global_irq_mask_on,
  output logic cycle_tick
);

  logic [1:0] phase;
  logic [acmvr_pkg::PC_W-1:0] pc;
  logic [acmvr_pkg::SP_W-1:0] sp;
  acmvr_pkg::acmvr_state_type state;
  logic [acmvr_pkg::PC_W-1:0] stack_head;
  logic [acmvr_pkg::DATA_W-1:0] result;
  logic dest_file;
  logic writes_acc;
  logic sets_zero;
  logic is_return;
  logic two_cycle;
  logic exec;
  acmvr_pkg::acmvr_op_type op;
  wire logic [acmvr_pkg::DATA_W-1:0] lit = instr[acmvr_pkg::DATA_W-1:0];
  wire logic [acmvr_pkg::PC_W-1:0] pc_inc = pc + acmvr_pkg::PC_ONE;
  wire logic [acmvr_pkg::PC_W-1:0] branch_target = {
    page_latch[acmvr_pkg::PAGE_HI:acmvr_pkg::PAGE_LO], instr[acmvr_pkg::BR_W-1:0]};
  wire logic [acmvr_pkg::SP_W-1:0] sp_pop = sp - 3'h1;
  wire logic [acmvr_pkg::SP_W-1:0] sp_push = sp + 3'h1;
  wire logic [acmvr_pkg::PC_W-1:0] next_pc = is_return ? stack_head
    : (op == acmvr_pkg::ACMVR_BRANCH) ? branch_target : pc_inc;

  // ****************************************
  // Instruction decode
  // ****************************************
  // Opcode to operation class
  function automatic acmvr_pkg::acmvr_op_type decode(input logic [13:0] w);
    if (w == acmvr_pkg::OPC_RETFROMIRQ) decode = acmvr_pkg::ACMVR_RETI;
    else if (w[13:7] == acmvr_pkg::OPC_STORE) decode = acmvr_pkg::ACMVR_STORE;
    else if (w[13:8] == acmvr_pkg::OPC_ORREG) decode = acmvr_pkg::ACMVR_ORREG;
    else if (w[13:8] == acmvr_pkg::OPC_MOVE) decode = acmvr_pkg::ACMVR_MOVE;
    else if (w[13:8] == acmvr_pkg::OPC_INC) decode = acmvr_pkg::ACMVR_INC;
    else if (w[13:8] == acmvr_pkg::OPC_ORLIT) decode = acmvr_pkg::ACMVR_ORLIT;
    else if (w[13:10] == acmvr_pkg::OPC_LDLIT) decode = acmvr_pkg::ACMVR_LDLIT;
    else if (w[13:10] == acmvr_pkg::OPC_RETLIT) decode = acmvr_pkg::ACMVR_RETLIT;
    else if (w[13:11] == acmvr_pkg::OPC_BRANCH) decode = acmvr_pkg::ACMVR_BRANCH;
    else decode = acmvr_pkg::ACMVR_NOP;
  endfunction : decode

  assign op = decode(instr);
  assign exec = cycle_tick && (state == acmvr_pkg::ACMVR_FETCH);
  assign dest_file = instr[acmvr_pkg::DEST_BIT];
  assign file_addr = instr[acmvr_pkg::ADDR_W-1:0];
  assign is_return = (op == acmvr_pkg::ACMVR_RETI) || (op == acmvr_pkg::ACMVR_RETLIT);
  assign two_cycle = is_return || (op == acmvr_pkg::ACMVR_BRANCH);
  assign sets_zero = (op == acmvr_pkg::ACMVR_ORLIT) || (op == acmvr_pkg::ACMVR_INC)
    || (op == acmvr_pkg::ACMVR_ORREG) || (op == acmvr_pkg::ACMVR_MOVE);

  // Result selection per operation
  assign result = (op == acmvr_pkg::ACMVR_ORLIT) ? (accum | lit) // RULE1
    : (op == acmvr_pkg::ACMVR_INC) ? (file_rdata + acmvr_pkg::DATA_ONE) // RULE2
    : (op == acmvr_pkg::ACMVR_ORREG) ? (accum | file_rdata) // RULE3
    : (op == acmvr_pkg::ACMVR_MOVE) ? file_rdata // RULE4
    : (op == acmvr_pkg::ACMVR_STORE) ? accum // RULE6
    : lit; // RULE5 RULE8

  // Destination selection
  assign writes_acc = (op == acmvr_pkg::ACMVR_ORLIT) || (op == acmvr_pkg::ACMVR_LDLIT)
    || (op == acmvr_pkg::ACMVR_RETLIT)
    || (((op == acmvr_pkg::ACMVR_INC) || (op == acmvr_pkg::ACMVR_ORREG)
    || (op == acmvr_pkg::ACMVR_MOVE)) && !dest_file);
  assign file_we = exec && ((op == acmvr_pkg::ACMVR_STORE)
    || (((op == acmvr_pkg::ACMVR_INC) || (op == acmvr_pkg::ACMVR_ORREG)
    || (op == acmvr_pkg::ACMVR_MOVE)) && dest_file));
  assign file_wdata = result;
  assign prog_addr = pc;

  // ****************************************
  // Instruction cycle timing
  // ****************************************
  // Four oscillator periods per instruction cycle
  always_ff @(posedge mclk) begin
    if (srst) phase <= 2'h0;
    else phase <= phase + 2'h1; // RULE9
  end
  assign cycle_tick = (phase == acmvr_pkg::PHASE_LAST);

  // ****************************************
  // Return stack
  // ****************************************
  acmvr_stack u_stack (
    .mclk(mclk),
    .wr_en(push_en && cycle_tick),
    .wr_addr(sp),
    .wr_data(push_addr),
    .rd_addr(sp_pop),
    .rd_data(stack_head)
  );

  // Stack pointer, pop on return, else push on call request
  always_ff @(posedge mclk) begin
    if (srst) sp <= 3'h0;
    else if (exec && is_return) sp <= sp_pop;
    else if (push_en && cycle_tick) sp <= sp_push;
  end

  // ****************************************
  // Execute
  // ****************************************
  // Program counter and flush sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc <= acmvr_pkg::PC_RESET;
      state <= acmvr_pkg::ACMVR_FETCH;
    end else if (cycle_tick) begin
      case (state)
        acmvr_pkg::ACMVR_FETCH: begin
          pc <= next_pc; // RULE7 RULE8 RULE10 RULE11
          state <= two_cycle ? acmvr_pkg::ACMVR_FLUSH : acmvr_pkg::ACMVR_FETCH;
        end
        default: begin
          state <= acmvr_pkg::ACMVR_FETCH;
        end
      endcase
    end
  end

  // Accumulator, zero flag and global enable
  always_ff @(posedge mclk) begin
    if (srst) begin
      accum <= acmvr_pkg::DATA_ZERO;
      zero_flag <= 1'b0;
      global_irq_mask_on <= 1'b0;
    end else if (exec) begin
      if (writes_acc) accum <= result;
      if (sets_zero) zero_flag <= (result == acmvr_pkg::DATA_ZERO); // RULE10
      if (op == acmvr_pkg::ACMVR_RETI) global_irq_mask_on <= 1'b1; // RULE7
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_orlit;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_ORLIT |=> accum == ($past(accum) | $past(lit))
      && zero_flag == (accum == 8'h00);
  endproperty
  a_orlit: assert property (p_orlit) else $error("or literal wrong"); // RULE1

  property p_inc;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_INC && dest_file |-> file_we
      && file_wdata == file_rdata + 8'h01 ##1 zero_flag == ($past(file_rdata) == 8'hff)
      && $stable(accum);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong"); // RULE2

  property p_orreg;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_ORREG && !dest_file
      |=> accum == ($past(accum) | $past(file_rdata));
  endproperty
  a_orreg: assert property (p_orreg) else $error("or register wrong"); // RULE3

  property p_move;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_MOVE && dest_file
      |-> file_we && file_wdata == file_rdata ##1 zero_flag == ($past(file_rdata) == 8'h00);
  endproperty
  a_move: assert property (p_move) else $error("move file wrong"); // RULE4

  property p_ldlit;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_LDLIT |=> accum == $past(lit) && $stable(zero_flag);
  endproperty
  a_ldlit: assert property (p_ldlit) else $error("load literal wrong"); // RULE5

  property p_store;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_STORE |-> file_we && file_wdata == accum ##1 $stable(zero_flag);
  endproperty
  a_store: assert property (p_store) else $error("store wrong"); // RULE6

  property p_reti;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_RETI |=> global_irq_mask_on && pc == $past(stack_head);
  endproperty
  a_reti: assert property (p_reti) else $error("interrupt return wrong"); // RULE7

  property p_retlit;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_RETLIT |=> accum == $past(lit)
      && pc == $past(stack_head) && $stable(zero_flag);
  endproperty
  a_retlit: assert property (p_retlit) else $error("literal return wrong"); // RULE8

  property p_twocyc;
    @(posedge mclk) disable iff (srst)
    exec && two_cycle |=> !exec [*7] ##1 exec;
  endproperty
  a_twocyc: assert property (p_twocyc) else $error("two cycle timing wrong"); // RULE8 RULE11

  property p_tick;
    @(posedge mclk) disable iff (srst)
    cycle_tick |=> !cycle_tick [*3] ##1 cycle_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("cycle rate wrong"); // RULE9

  property p_nop;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_NOP |=> $stable(accum) && $stable(zero_flag)
      && pc == $past(pc) + 13'h0001;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state"); // RULE10

  property p_branch;
    @(posedge mclk) disable iff (srst)
    exec && op == acmvr_pkg::ACMVR_BRANCH |=> pc == {
      $past(page_latch[acmvr_pkg::PAGE_HI:acmvr_pkg::PAGE_LO]),
      $past(instr[acmvr_pkg::BR_W-1:0])};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong"); // RULE11

  c_reti: cover property (@(posedge mclk) exec && op == acmvr_pkg::ACMVR_RETI);
  c_retlit: cover property (@(posedge mclk) exec && op == acmvr_pkg::ACMVR_RETLIT);
  c_zero: cover property (@(posedge mclk) exec && sets_zero && result == 8'h00);
  c_inc_file: cover property (@(posedge mclk) exec && op == acmvr_pkg::ACMVR_INC && dest_file);
endmodule : acmvr_core

// [core/acmvr_pkg.sv]
// Constants and types for the accumulator, move and return instruction sequencer
// Summary of operation
// [RULE1] OR an 8-bit literal into the accumulator, update zero flag.
// [RULE2] Increment addressed register, result to accumulator or register by target bit.
// [RULE3] OR accumulator with register, result to accumulator or register, update zero.
// [RULE4] Move register to accumulator or back to itself, always update zero.
// [RULE5] Load 8-bit literal into accumulator, flags unchanged.
// [RULE6] Store accumulator into addressed register, flags unchanged.
// [RULE7] Interrupt return loads PC from stack head and sets global enable.
// [RULE8] Literal return loads accumulator from literal and PC from stack head, two cycles.
// [RULE9] One instruction cycle spans four oscillator periods.
// [RULE10] Zero flag set when result is zero; no-op changes only the PC.
// [RULE11] Branch loads 11-bit immediate low, page latch high, two cycles.
package acmvr_pkg;
  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int OP_W = 14;
  localparam int BR_W = 11;
  localparam int DEST_BIT = 7;
  localparam int PAGE_LO = 3;
  localparam int PAGE_HI = 4;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // ****************************************
  // Reset values and opcodes
  // ****************************************
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [OP_W-1:0] OPC_NOP = 14'h0000;
  localparam logic [OP_W-1:0] OPC_RETFROMIRQ = 14'h0009;
  localparam logic [5:0] OPC_ORREG = 6'h04;
  localparam logic [5:0] OPC_MOVE = 6'h08;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [6:0] OPC_STORE = 7'h01;
  localparam logic [5:0] OPC_ORLIT = 6'h38;
  localparam logic [3:0] OPC_LDLIT = 4'hc;
  localparam logic [3:0] OPC_RETLIT = 4'hd;
  localparam logic [2:0] OPC_BRANCH = 3'h5;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ACMVR_NOP = 4'h0, ACMVR_ORLIT = 4'h1, ACMVR_INC = 4'h2, ACMVR_ORREG = 4'h3,
    ACMVR_MOVE = 4'h4, ACMVR_LDLIT = 4'h5, ACMVR_STORE = 4'h6, ACMVR_RETI = 4'h7,
    ACMVR_RETLIT = 4'h8, ACMVR_BRANCH = 4'h9
  } acmvr_op_type;
  typedef enum logic [1:0] {
    ACMVR_FETCH = 2'h0, ACMVR_FLUSH = 2'h1
  } acmvr_state_type;
endpackage : acmvr_pkg

// [core/acmvr_stack.sv]
// Return address stack memory with registered read data
`timescale 1ns/1ps
module acmvr_stack #(
  parameter int DEPTH = acmvr_pkg::STACK_DEPTH,
  parameter int WIDTH = acmvr_pkg::PC_W,
  parameter int AW = acmvr_pkg::SP_W
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************
  // Storage and registered read
  // ****************************************
  // Write port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : acmvr_stack

// [testbench/acmvr_core_test.sv]
// Self-checking bench for the accumulator, move and return sequencer
`timescale 1ns/1ps
module acmvr_core_test;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk;
  logic srst;
  logic [acmvr_pkg::OP_W-1:0] instr;
  logic [acmvr_pkg::DATA_W-1:0] page_latch;
  logic push_en;
  logic [acmvr_pkg::PC_W-1:0] push_addr;
  logic [acmvr_pkg::PC_W-1:0] prog_addr;
  logic [acmvr_pkg::ADDR_W-1:0] file_addr;
  logic file_we;
  logic [acmvr_pkg::DATA_W-1:0] file_wdata;
  logic [acmvr_pkg::DATA_W-1:0] file_rdata;
  logic [acmvr_pkg::DATA_W-1:0] accum;
  logic zero_flag;
  logic global_irq_mask_on;
  logic cycle_tick;
  logic [7:0] regs [128];
  logic [12:0] pc_m;
  logic [12:0] pc_s;
  logic irq_s;
  logic we_s;
  logic [7:0] wd_s;
  logic [6:0] ad_s;
  logic first;
  int bad_count;
  int cmp_count;

  acmvr_core i_dut (
    .mclk(mclk), .srst(srst), .instr(instr), .file_rdata(file_rdata),
    .page_latch(page_latch), .push_en(push_en), .push_addr(push_addr),
    .prog_addr(prog_addr), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .accum(accum), .zero_flag(zero_flag),
    .global_irq_mask_on(global_irq_mask_on), .cycle_tick(cycle_tick)
  );

  // Clock source
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Register file seen by the core
  assign file_rdata = regs[file_addr];
  always @(posedge mclk) begin
    if (file_we === 1'b1) begin
      regs[file_addr] <= file_wdata;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // One instruction slot, optionally pushing a return address at its tick
  task automatic step(input logic [13:0] w, input logic [12:0] pa);
    int n;
    n = 0;
    instr = w;
    while (cycle_tick !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (!first) check("tick_gap", 16'(n), 16'h0003);
    first = 1'b0;
    push_en = (pa != 13'h0000);
    push_addr = pa;
    we_s = file_we;
    wd_s = file_wdata;
    ad_s = file_addr;
    @(negedge mclk);
    push_en = 1'b0;
    pc_s = prog_addr;
    irq_s = global_irq_mask_on;
  endtask : step

  // Execute and judge accumulator, flag, write strobe and counter
  task automatic op(input logic [13:0] w, input logic two, input logic [12:0] pa,
      input logic [7:0] acc, input logic z, input logic we, input logic [7:0] wd);
    step(w, pa);
    check("accum", 16'(accum), 16'(acc));
    check("zero_flag", 16'(zero_flag), 16'(z));
    check("file_we", 16'(we_s), 16'(we));
    if (we) begin
      check("file_wdata", 16'(wd_s), 16'(wd));
      check("file_addr", 16'(ad_s), 16'(w[6:0]));
    end
    if (!two) begin
      pc_m++;
      check("prog_addr", 16'(pc_s), 16'(pc_m));
    end else begin
      step(14'h30ee, 13'h0000);
      check("flush_accum", 16'(accum), 16'(acc));
    end
  endtask : op

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check("accum", 16'(accum), 16'h0000);
    check("zero_flag", 16'(zero_flag), 16'h0000);
    check("irq_on", 16'(global_irq_mask_on), 16'h0000);
    check("prog_addr", 16'(prog_addr), 16'h0000);
  endtask : t_reset

  // Reset in mid-run, after the global enable has been set
  task automatic t_midreset;
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    pc_m = 13'h0000;
    t_reset();
  endtask : t_midreset

  task automatic t_literal;
    op(14'h3000, 0, 0, 8'h00, 0, 0, 8'h00);
    op(14'h3800, 0, 0, 8'h00, 1, 0, 8'h00);
    op(14'h305a, 0, 0, 8'h5a, 1, 0, 8'h00);
    op(14'h38a5, 0, 0, 8'hff, 0, 0, 8'h00);
    op(14'h3000, 0, 0, 8'h00, 0, 0, 8'h00);
    op(14'h38ff, 0, 0, 8'hff, 0, 0, 8'h00);
  endtask : t_literal

  task automatic t_file;
    op(14'h0a05, 0, 0, 8'h00, 1, 0, 8'h00);
    op(14'h0a86, 0, 0, 8'h00, 0, 1, 8'h80);
    op(14'h3003, 0, 0, 8'h03, 0, 0, 8'h00);
    op(14'h0409, 0, 0, 8'h33, 0, 0, 8'h00);
    op(14'h0486, 0, 0, 8'h33, 0, 1, 8'hb3);
    op(14'h0806, 0, 0, 8'hb3, 0, 0, 8'h00);
    op(14'h0887, 0, 0, 8'hb3, 1, 1, 8'h00);
    op(14'h00ff, 0, 0, 8'hb3, 1, 1, 8'hb3);
    check("reg_127", 16'(regs[127]), 16'h00b3);
  endtask : t_file

  task automatic t_nop;
    op(14'h0000, 0, 0, 8'hb3, 1, 0, 8'h00);
    op(14'h3801, 0, 0, 8'hb3, 0, 0, 8'h00);
  endtask : t_nop

  task automatic t_returns;
    op(14'h0000, 0, 13'h0abc, 8'hb3, 0, 0, 8'h00);
    op(14'h0000, 0, 13'h1234, 8'hb3, 0, 0, 8'h00);
    op(14'h3400, 1, 0, 8'h00, 0, 0, 8'h00);
    check("ret_pc", 16'(pc_s), 16'h1234);
    op(14'h0009, 1, 0, 8'h00, 0, 0, 8'h00);
    check("reti_pc", 16'(pc_s), 16'h0abc);
    check("irq_on", 16'(irq_s), 16'h0001);
  endtask : t_returns

  task automatic t_branch;
    page_latch = 8'hf9;
    op(14'h2da3, 1, 0, 8'h00, 0, 0, 8'h00);
    check("br_pc", 16'(pc_s), 16'h1da3);
    page_latch = 8'he7;
    op(14'h28ff, 1, 0, 8'h00, 0, 0, 8'h00);
    check("br_pc", 16'(pc_s), 16'h00ff);
  endtask : t_branch

  // Main sequence
  initial begin
    srst = 1'b1;
    instr = 14'h0000;
    page_latch = 8'h00;
    push_en = 1'b0;
    push_addr = 13'h0000;
    bad_count = 0;
    cmp_count = 0;
    pc_m = 13'h0000;
    first = 1'b1;
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'h00;
    end
    regs[5] = 8'hff;
    regs[6] = 8'h7f;
    regs[9] = 8'h30;
    regs[127] = 8'h5c;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    t_reset();
    t_literal();
    t_file();
    t_nop();
    t_returns();
    t_midreset();
    t_branch();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : acmvr_core_test
